/* rtl/gpc_pin_ctl.sv */
// control logic for one general-purpose pin with an Avalon-MM register slave
//
// Functional notes
// [R1] bit15 direction, bit9 open-drain driver
// [R2] bits14:13 pull select, reset pull-down
// [R3] edge mode: interrupt on both edges
// [R4] else edge follows polarity setting
// [R5] bit11 picks I/O buffer supply
// [R6] bit10 polarity, zero inverts, reset one
// [R7] bit7 clear keeps pin tri-stated
// [R8] input codes 0/1: general input, debounce
// [R9] input codes 2-6: power/sleep requests
// [R10] input 7 watchdog, 8/9 voltage select
// [R11] input 10-15 hardware enable and control
// [R12] output 0 software level, 1 oscillator
// [R13] output 2-4 power states, 5 reserved
// [R14] output 6-9 touch and scaling done
// [R15] output 10-13 enables and power good
// [R16] output 14 2MHz clock, 15 aux reset
// [R17] pin synchronised, debounce lengths parameterised
// [R18] pin edge sets sticky status flag
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
module gpc_pin_ctl #(
  parameter int NORM_CYC = `GPC_DB_NORM_CYC,
  parameter int LONG_CYC = `GPC_DB_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  // pin
  input wire logic pin_in,
  output var logic pin_out,
  output var logic pin_oe,
  output var logic pull_up_en,
  output var logic pull_down_en,
  output var logic io_supply_sel,
  // device side
  input wire gpc_pkg::gpc_src_t int_src,
  output var gpc_pkg::gpc_req_t req,
  output var logic irq
);
  import gpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic long_db(input logic [3:0] fn);
    long_db = (fn == GPC_IN_GEN_LONG) || (fn == GPC_IN_SLEEP_WAKE_LONG) ||
              (fn == GPC_IN_HW_CTL_ONE_LONG) || (fn == GPC_IN_HW_CTL_TWO_LONG);
  endfunction : long_db

  function automatic gpc_req_t in_req(input logic [3:0] fn, input logic act);
    gpc_req_t r;
    r = '0;
    unique case (gpc_in_fn_t'(fn))
      GPC_IN_GEN_LONG, GPC_IN_GEN: r = '0;
      GPC_IN_PWR_ONOFF: r.power_onoff = act;
      GPC_IN_SLEEP_WAKE, GPC_IN_SLEEP_WAKE_LONG: r.sleep_wake = act;
      GPC_IN_SLEEP: r.sleep_req = act;
      GPC_IN_PWR_ON: r.power_on = act;
      GPC_IN_WDOG: r.wdog_reset = act;
      GPC_IN_VSEL_ONE: r.voltage_scaling_sel_one = act;
      GPC_IN_VSEL_TWO: r.voltage_scaling_sel_two = act;
      GPC_IN_HW_EN_ONE: r.hw_enable_one = act;
      GPC_IN_HW_EN_TWO: r.hw_enable_two = act;
      GPC_IN_HW_CTL_ONE, GPC_IN_HW_CTL_ONE_LONG: r.hw_control_one = act;
      GPC_IN_HW_CTL_TWO, GPC_IN_HW_CTL_TWO_LONG: r.hw_control_two = act;
    endcase
    in_req = r;
  endfunction : in_req

  ////////////////////////////////////////////////////////////////////////////
  // registers and bus decode

  gpc_ctrl_t ctrl_r;
  logic outlvl_r;
  logic status_r;
  logic irq_en_r;
  logic irq_r;
  logic wait_r;
  logic [31:0] rdata_r;

  wire bus_req = avs_read | avs_write;
  wire wr_fire = avs_write & ~wait_r;
  wire rd_load = avs_read & wait_r;
  wire wait_nxt = ~(bus_req & wait_r);

  wire hit_ctrl = (avs_address == `GPC_ADDR_CTRL);
  wire hit_out = (avs_address == `GPC_ADDR_OUTLVL);
  wire hit_st = (avs_address == `GPC_ADDR_STATUS);
  wire hit_clr = (avs_address == `GPC_ADDR_IRQ_CLR);
  wire hit_en = (avs_address == `GPC_ADDR_IRQ_EN);
  wire hit_lvl = (avs_address == `GPC_ADDR_PIN_LVL);

  wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] ctrl_wr = (ctrl_r & ~be_mask) | (avs_writedata[15:0] & be_mask);
  wire lane0_wr = wr_fire & avs_byteenable[0];

  // reserved control bits never store, so they read back as zero
  wire gpc_ctrl_t ctrl_nxt = (wr_fire && hit_ctrl) ?
                             gpc_ctrl_t'(ctrl_wr & `GPC_CTRL_WMASK) : ctrl_r; // [R1] [R2]
  wire outlvl_nxt = (lane0_wr && hit_out) ? avs_writedata[0] : outlvl_r;
  wire irq_en_nxt = (lane0_wr && hit_en) ? avs_writedata[`GPC_ST_EDGE] : irq_en_r;

  logic db_lvl;
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_r} :
                       hit_out ? {31'h0000_0000, outlvl_r} :
                       hit_st ? {31'h0000_0000, status_r} :
                       hit_en ? {31'h0000_0000, irq_en_r} :
                       hit_lvl ? {31'h0000_0000, db_lvl} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= gpc_ctrl_t'(`GPC_CTRL_RST); // [R1] [R2] [R5] [R6] [R7] [R8]
      outlvl_r <= 1'b0;
      irq_en_r <= 1'b0;
      wait_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      outlvl_r <= outlvl_nxt;
      irq_en_r <= irq_en_nxt;
      wait_r <= wait_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_load) begin
      rdata_r <= rd_mux;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // input path

  logic pin_sync;

  gpc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(pin_in),
    .dout(pin_sync)
  ); // [R17]

  wire db_long = long_db(ctrl_r.pin_function_sel); // [R8]

  gpc_debounce #(
    .NORM_CYC(NORM_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_db (
    .clk(clk),
    .rst_n(rst_n),
    .din(pin_sync),
    .long_sel(db_long),
    .lvl(db_lvl)
  ); // [R17]

  wire in_mode = ctrl_r.pin_enable_ctl & ctrl_r.pin_direction_sel;
  wire act_lvl = db_lvl ^ ~ctrl_r.polarity_sel; // [R6]

  logic db_prev_r;
  wire rise = db_lvl & ~db_prev_r;
  wire fall = ~db_lvl & db_prev_r;
  // edges are taken from the raw level so a polarity write makes none
  wire edge_hit = in_mode & (ctrl_r.edge_mode_sel ? (rise | fall) : // [R3]
                             (ctrl_r.polarity_sel ? rise : fall)); // [R4]

  gpc_req_t req_r;
  wire gpc_req_t req_nxt = in_mode ? in_req(ctrl_r.pin_function_sel, act_lvl) : '0; // [R9]

  // set wins over a clear in the same cycle
  wire clr_edge = lane0_wr & hit_clr & avs_writedata[`GPC_ST_EDGE];
  wire status_nxt = edge_hit | (status_r & ~clr_edge); // [R18]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      db_prev_r <= 1'b0;
      status_r <= 1'b0;
      irq_r <= 1'b0;
      req_r <= '0;
    end else begin
      db_prev_r <= db_lvl;
      status_r <= status_nxt; // [R18]
      irq_r <= status_nxt & irq_en_nxt;
      req_r <= req_nxt; // [R10] [R11]
    end
  end

  assign req = req_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // output path

  // code 5 is reserved and drives the inactive level
  wire [15:0] out_vec = {int_src.aux_reset, int_src.ext_clk_2m, // [R16]
                         int_src.converter_power_good, int_src.system_supply_good, // [R15]
                         int_src.ext_pwr_en_two, int_src.ext_pwr_en_one, // [R15]
                         int_src.buck_two_scaled, int_src.buck_one_scaled, // [R14]
                         int_src.conv_done, int_src.pen_down, 1'b0, // [R14] [R13]
                         int_src.pwr_change, int_src.sleep_state, int_src.on_state, // [R13]
                         int_src.osc_32k, outlvl_r}; // [R12]
  wire out_sel = out_vec[ctrl_r.pin_function_sel];
  wire drv_lvl = out_sel ^ ~ctrl_r.polarity_sel; // [R6]
  wire out_mode = ctrl_r.pin_enable_ctl & ~ctrl_r.pin_direction_sel; // [R7]
  // open drain only ever pulls low; high comes from the pull or the board
  wire oe_nxt = out_mode & (ctrl_r.open_drain_sel ? ~drv_lvl : 1'b1); // [R1]
  wire out_nxt = ctrl_r.open_drain_sel ? 1'b0 : drv_lvl; // [R1]
  wire pu_nxt = (ctrl_r.pull_resistor_cfg == `GPC_PULL_UP); // [R2]
  wire pd_nxt = (ctrl_r.pull_resistor_cfg == `GPC_PULL_DOWN); // [R2]

  logic pin_out_r;
  logic pin_oe_r;
  logic pull_up_r;
  logic pull_dn_r;
  logic supply_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
      pull_up_r <= 1'b0;
      pull_dn_r <= 1'b1;
      supply_r <= 1'b0;
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt; // [R7]
      pull_up_r <= pu_nxt;
      pull_dn_r <= pd_nxt;
      supply_r <= ctrl_r.io_supply_sel; // [R5]
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pull_up_en = pull_up_r;
  assign pull_down_en = pull_dn_r;
  assign io_supply_sel = supply_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  drive_enable_a: assert property ( // [R7]
    pin_oe |-> $past(ctrl_r.pin_enable_ctl && !ctrl_r.pin_direction_sel))
    else $error("pin driven while disabled or input");

  open_drain_a: assert property ( // [R1]
    (pin_oe && $past(ctrl_r.open_drain_sel)) |-> !pin_out)
    else $error("open drain drove high");

  pull_map_a: assert property ( // [R2]
    ##1 (pull_down_en == ($past(ctrl_r.pull_resistor_cfg) == 2'h1)) &&
    (pull_up_en == ($past(ctrl_r.pull_resistor_cfg) == 2'h2)))
    else $error("pull enables do not follow config");

  both_edge_a: assert property ( // [R3]
    (in_mode && ctrl_r.edge_mode_sel && $changed(db_lvl)) |=> status_r)
    else $error("edge missed in both-edge mode");

  pol_edge_a: assert property ( // [R4]
    (in_mode && !ctrl_r.edge_mode_sel && (ctrl_r.polarity_sel ? $fell(db_lvl)
     : $rose(db_lvl)) && !status_r && !$past(status_r)) |-> !status_nxt)
    else $error("wrong edge raised interrupt");

  supply_sel_a: assert property ( // [R5]
    $changed(ctrl_r.io_supply_sel) |=> (io_supply_sel == $past(ctrl_r.io_supply_sel)))
    else $error("supply select lags");

  push_pull_a: assert property ( // [R6]
    (out_mode && !ctrl_r.open_drain_sel) |=> pin_oe && (pin_out == $past(drv_lvl)))
    else $error("push-pull level wrong");

  reserved_out_a: assert property ( // [R13]
    (out_mode && !ctrl_r.open_drain_sel && ctrl_r.pin_function_sel == 4'h5)
    |=> pin_out == !$past(ctrl_r.polarity_sel))
    else $error("reserved code drove active level");

  long_db_a: assert property ( // [R8]
    (ctrl_r.pin_function_sel == 4'h0 || ctrl_r.pin_function_sel == 4'hE) |-> db_long)
    else $error("long debounce not chosen");

  power_on_a: assert property ( // [R9]
    req.power_on |-> $past(in_mode && ctrl_r.pin_function_sel == 4'h6 && act_lvl))
    else $error("power-on request without cause");

  wdog_req_a: assert property ( // [R10]
    req.wdog_reset |-> $past(in_mode && ctrl_r.pin_function_sel == 4'h7 && act_lvl))
    else $error("watchdog request without cause");

  sticky_flag_a: assert property ( // [R18]
    (status_r && !clr_edge) |=> status_r)
    else $error("status flag dropped by itself");

  flag_clear_a: assert property ( // [R18]
    (clr_edge && !edge_hit) |=> !status_r)
    else $error("status flag survived a clear");

  bus_answer_a: assert property (
    (bus_req && wait_r) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle later");

  irq_level_a: assert property (
    irq |-> $past(status_nxt && irq_en_nxt))
    else $error("interrupt without enabled status");

  both_edge_c: cover property (in_mode && ctrl_r.edge_mode_sel && fall ##1 status_r);
  open_drain_c: cover property (pin_oe && $past(ctrl_r.open_drain_sel));
  read_c: cover property (avs_read && !avs_waitrequest);
  power_on_c: cover property ($rose(req.power_on));
endmodule : gpc_pin_ctl
`default_nettype wire

/* shared/gpc_params.svh */
// constants for the general pin control block
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// byte addresses on the register bus
`define GPC_ADDR_CTRL 16'h4038
`define GPC_ADDR_OUTLVL 16'h403C
`define GPC_ADDR_STATUS 16'h4040
`define GPC_ADDR_IRQ_CLR 16'h4044
`define GPC_ADDR_IRQ_EN 16'h4048
`define GPC_ADDR_PIN_LVL 16'h404C

// control register reset value and writable bits
`define GPC_CTRL_RST 16'hA400
`define GPC_CTRL_WMASK 16'hFE8F

// pull field codes
`define GPC_PULL_DOWN 2'h1
`define GPC_PULL_UP 2'h2

// status and enable bit positions
`define GPC_ST_EDGE 0

// debounce timing
`define GPC_CLK_MHZ 200
`define GPC_DB_NORM_NS 1000
`define GPC_DB_LONG_NS 20000
`define GPC_DB_NORM_CYC ((`GPC_DB_NORM_NS * `GPC_CLK_MHZ) / 1000)
`define GPC_DB_LONG_CYC ((`GPC_DB_LONG_NS * `GPC_CLK_MHZ) / 1000)

`endif

/* shared/gpc_pkg.sv */
// types for the general pin control block
package gpc_pkg;

  typedef struct packed {
    logic pin_direction_sel;
    logic [1:0] pull_resistor_cfg;
    logic edge_mode_sel;
    logic io_supply_sel;
    logic polarity_sel;
    logic open_drain_sel;
    logic rsv8;
    logic pin_enable_ctl;
    logic [2:0] rsv6_4;
    logic [3:0] pin_function_sel;
  } gpc_ctrl_t;

  typedef enum logic [3:0] {
    GPC_IN_GEN_LONG = 4'h0,
    GPC_IN_GEN = 4'h1,
    GPC_IN_PWR_ONOFF = 4'h2,
    GPC_IN_SLEEP_WAKE = 4'h3,
    GPC_IN_SLEEP_WAKE_LONG = 4'h4,
    GPC_IN_SLEEP = 4'h5,
    GPC_IN_PWR_ON = 4'h6,
    GPC_IN_WDOG = 4'h7,
    GPC_IN_VSEL_ONE = 4'h8,
    GPC_IN_VSEL_TWO = 4'h9,
    GPC_IN_HW_EN_ONE = 4'hA,
    GPC_IN_HW_EN_TWO = 4'hB,
    GPC_IN_HW_CTL_ONE = 4'hC,
    GPC_IN_HW_CTL_TWO = 4'hD,
    GPC_IN_HW_CTL_ONE_LONG = 4'hE,
    GPC_IN_HW_CTL_TWO_LONG = 4'hF
  } gpc_in_fn_t;

  // internal signals that may be routed out to the pin
  typedef struct packed {
    logic aux_reset;
    logic ext_clk_2m;
    logic converter_power_good;
    logic system_supply_good;
    logic ext_pwr_en_two;
    logic ext_pwr_en_one;
    logic buck_two_scaled;
    logic buck_one_scaled;
    logic conv_done;
    logic pen_down;
    logic pwr_change;
    logic sleep_state;
    logic on_state;
    logic osc_32k;
  } gpc_src_t;

  // requests the pin may raise into the device
  typedef struct packed {
    logic power_onoff;
    logic sleep_wake;
    logic sleep_req;
    logic power_on;
    logic wdog_reset;
    logic voltage_scaling_sel_one;
    logic voltage_scaling_sel_two;
    logic hw_enable_one;
    logic hw_enable_two;
    logic hw_control_one;
    logic hw_control_two;
  } gpc_req_t;

endpackage : gpc_pkg

/* rtl/gpc_sync.sv */
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module gpc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level
  input wire logic din,
  output var logic dout
);
  logic meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : gpc_sync
`default_nettype wire

/* rtl/gpc_debounce.sv */
// debouncer with a normal and a long settle time
`timescale 1ns/1ps
`default_nettype none
module gpc_debounce #(
  parameter int NORM_CYC = 200,
  parameter int LONG_CYC = 4000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic din,
  input wire logic long_sel,
  output var logic lvl
);
  localparam int CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] NORM_LIM = CW'(NORM_CYC);
  localparam logic [CW-1:0] LONG_LIM = CW'(LONG_CYC);

  logic [CW-1:0] cnt_r;
  wire [CW-1:0] limit = long_sel ? LONG_LIM : NORM_LIM;
  wire [CW-1:0] cnt_inc = cnt_r + CW'(1);
  wire settled = (cnt_inc >= limit);

  // any bounce back to the held level restarts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      lvl <= 1'b0;
    end else if (din == lvl) begin
      cnt_r <= '0;
    end else if (settled) begin
      cnt_r <= '0;
      lvl <= din;
    end else begin
      cnt_r <= cnt_inc;
    end
  end
endmodule : gpc_debounce
`default_nettype wire

/* testbench/gpc_pin_model.sv */
// far-side model of the pin: external driver, pulls and a floating line
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_model (
  // clock
  input wire logic clk,
  // block side
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // external driver
  input wire logic ext_lvl,
  input wire logic ext_oe,
  // resolved wire
  output var logic pin_in
);
  logic flt_r = 1'b0;

  // an undriven line wanders rather than keeping its last value
  always @(posedge clk) begin
    flt_r <= ~flt_r;
  end

  always_comb begin
    if (pin_oe) begin
      pin_in = pin_out;
    end else if (ext_oe) begin
      pin_in = ext_lvl;
    end else if (pull_up_en) begin
      pin_in = 1'b1;
    end else if (pull_down_en) begin
      pin_in = 1'b0;
    end else begin
      pin_in = flt_r;
    end
  end
endmodule : gpc_pin_model
`default_nettype wire

/* testbench/gpc_pin_ctl_tb.sv */
// self-checking bench for the general pin control block
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
module gpc_pin_ctl_tb;
  import gpc_pkg::*;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, io_supply_sel, irq;
  logic ext_lvl, ext_oe;
  gpc_src_t int_src;
  gpc_req_t req;
  logic [13:0] oh;
  int error_cnt = 0;
  int comparisons = 0;

  gpc_pin_ctl #(.NORM_CYC(4), .LONG_CYC(8)) gpc_pin_ctl_inst (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .io_supply_sel(io_supply_sel), .int_src(int_src), .req(req), .irq(irq));

  gpc_pin_model gpc_pin_model_inst (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_lvl(ext_lvl), .ext_oe(ext_oe), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    chk("bus_answer", 32'(n < 64), 32'h1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(nm, q, exp);
  endtask : rdc

  function automatic logic [15:0] cfg(input logic dir, input logic [1:0] pl, input logic md,
                                      input logic pol, input logic od, input logic en,
                                      input logic [3:0] fn);
    return {dir, pl, md, 1'b0, pol, od, 1'b0, en, 3'h0, fn};
  endfunction : cfg

  function automatic gpc_req_t exp_req(input logic [3:0] c);
    gpc_req_t r;
    r = '0;
    case (c)
      4'h2: r.power_onoff = 1'b1;
      4'h3, 4'h4: r.sleep_wake = 1'b1;
      4'h5: r.sleep_req = 1'b1;
      4'h6: r.power_on = 1'b1;
      4'h7: r.wdog_reset = 1'b1;
      4'h8: r.voltage_scaling_sel_one = 1'b1;
      4'h9: r.voltage_scaling_sel_two = 1'b1;
      4'hA: r.hw_enable_one = 1'b1;
      4'hB: r.hw_enable_two = 1'b1;
      4'hC, 4'hE: r.hw_control_one = 1'b1;
      4'hD, 4'hF: r.hw_control_two = 1'b1;
      default: r = '0;
    endcase
    return r;
  endfunction : exp_req

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    error_cnt++;
    conclude();
  end

  initial begin
    logic seen;
    rst_b = 1'b0;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ext_lvl = 1'b0;
    ext_oe = 1'b1;
    int_src = '0;
    tick(16);
    rst_b <= 1'b1;
    tick(4);
    chk("pull_down_rst", pull_down_en, 32'h1);
    chk("oe_rst", pin_oe, 32'h0);
    chk("supply_rst", io_supply_sel, 32'h0);
    rdc("ctrl_rst", `GPC_ADDR_CTRL, 32'h0000A400);
    rdc("unmapped", 16'h4050, 32'h0);
    wr(`GPC_ADDR_CTRL, 16'hFFFF);
    rdc("ctrl_mask", `GPC_ADDR_CTRL, 32'h0000FE8F);
    chk("supply_one", io_supply_sel, 32'h1);
    for (int pl = 0; pl < 4; pl++) begin
      wr(`GPC_ADDR_CTRL, cfg(1'b1, pl[1:0], 1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
      tick(2);
      chk("pull_up", pull_up_en, 32'(pl == 2));
      chk("pull_down", pull_down_en, 32'(pl == 1));
    end
    // output driver, polarity, open drain, enable
    wr(`GPC_ADDR_OUTLVL, 16'h0001);
    wr(`GPC_ADDR_CTRL, cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0));
    tick(2);
    chk("oe_push", pin_oe, 32'h1);
    chk("out_sw", pin_out, 32'h1);
    wr(`GPC_ADDR_CTRL, cfg(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
    tick(2);
    chk("out_inv", pin_out, 32'h0);
    wr(`GPC_ADDR_CTRL, cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0));
    tick(2);
    chk("od_high_oe", pin_oe, 32'h0);
    chk("od_out", pin_out, 32'h0);
    wr(`GPC_ADDR_OUTLVL, 16'h0000);
    tick(2);
    chk("od_low_oe", pin_oe, 32'h1);
    wr(`GPC_ADDR_CTRL, cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
    tick(2);
    chk("oe_disabled", pin_oe, 32'h0);
    // output sources 1 to 15, code 5 stays inactive
    for (int c = 1; c < 16; c++) begin
      oh = (c == 5) ? 14'h3FFF : 14'h0001 << ((c <= 4) ? c - 1 : c - 2);
      wr(`GPC_ADDR_CTRL, cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, c[3:0]));
      int_src <= gpc_src_t'(oh);
      tick(3);
      chk("src_on", pin_out, 32'(c != 5));
      int_src <= gpc_src_t'(~oh);
      tick(3);
      chk("src_off", pin_out, 32'h0);
    end
    int_src <= '0;
    // every input function
    for (int c = 0; c < 16; c++) begin
      wr(`GPC_ADDR_CTRL, cfg(1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, c[3:0]));
      ext_lvl <= 1'b1;
      tick(24);
      chk("req_on", {21'h0, req}, {21'h0, exp_req(c[3:0])});
      if (c < 2) begin
        rdc("pin_level", `GPC_ADDR_PIN_LVL, 32'h1);
      end
      ext_lvl <= 1'b0;
      tick(24);
      chk("req_off", {21'h0, req}, 32'h0);
    end
    // inverted polarity turns a low pin into an active request
    wr(`GPC_ADDR_CTRL, cfg(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h6));
    tick(4);
    chk("req_inv", {21'h0, req}, {21'h0, exp_req(4'h6)});
    // a six-cycle pulse passes normal debounce only
    for (int c = 12; c < 16; c += 2) begin
      wr(`GPC_ADDR_CTRL, cfg(1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, c[3:0]));
      seen = 1'b0;
      ext_lvl <= 1'b1;
      for (int i = 0; i < 30; i++) begin
        @(posedge clk);
        if (i == 5) begin
          ext_lvl <= 1'b0;
        end
        if (req.hw_control_one === 1'b1) begin
          seen = 1'b1;
        end
      end
      chk("glitch", seen, 32'(c == 12));
    end
    // edge interrupt per mode and polarity
    wr(`GPC_ADDR_IRQ_EN, 16'h0001);
    rdc("irq_en", `GPC_ADDR_IRQ_EN, 32'h1);
    for (int m = 0; m < 2; m++) begin
      for (int p = 0; p < 2; p++) begin
        wr(`GPC_ADDR_CTRL, cfg(1'b1, 2'h0, m[0], p[0], 1'b0, 1'b1, 4'h1));
        tick(24);
        wr(`GPC_ADDR_IRQ_CLR, 16'h0001);
        rdc("st_clear", `GPC_ADDR_STATUS, 32'h0);
        chk("irq_clear", irq, 32'h0);
        ext_lvl <= 1'b1;
        tick(24);
        rdc("st_rise", `GPC_ADDR_STATUS, 32'(m | p));
        chk("irq_rise", irq, 32'(m | p));
        wr(`GPC_ADDR_IRQ_CLR, 16'h0001);
        ext_lvl <= 1'b0;
        tick(24);
        rdc("st_fall", `GPC_ADDR_STATUS, 32'(m | (p ^ 1)));
        wr(`GPC_ADDR_IRQ_CLR, 16'h0001);
      end
    end
    // masking leaves the flag sticky
    ext_lvl <= 1'b1;
    tick(24);
    wr(`GPC_ADDR_IRQ_EN, 16'h0000);
    wr(`GPC_ADDR_STATUS, 16'h0000);
    tick(2);
    chk("irq_masked", irq, 32'h0);
    rdc("st_sticky", `GPC_ADDR_STATUS, 32'h1);
    wr(`GPC_ADDR_IRQ_CLR, 16'h0001);
    rdc("st_cleared", `GPC_ADDR_STATUS, 32'h0);
    // released line settles at the selected pull
    ext_oe <= 1'b0;
    wr(`GPC_ADDR_CTRL, cfg(1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h1));
    tick(24);
    rdc("pin_pulled_dn", `GPC_ADDR_PIN_LVL, 32'h0);
    wr(`GPC_ADDR_CTRL, cfg(1'b1, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 4'h1));
    tick(24);
    rdc("pin_pulled_up", `GPC_ADDR_PIN_LVL, 32'h1);
    conclude();
  end
endmodule : gpc_pin_ctl_tb
`default_nettype wire
